// file: dcid_decoder.sv
// instruction decoder with fetch port and apb register slave
// Function
// - 24-bit word, top 8 bits opcode
// - exactly three instructions take two words
// - two-word operands from 48 bits, zero top
// - lone second word executes as nop
// - one cycle, two when taken or pc changes
// - branches, tables, returns take two or three
// - taken skip: two or three by skipped size
// - double moves and two-word instructions: two cycles
// - word ops: base, second source, result operands
// - file ops: address, destination file or w0
// - file address covers 0 to 0x1fff
// - unsigned ten-bit literal: byte limit 255
// - program address literal forced even once both words are in
// - signed literals sign-extended, ten and sixteen bits
// - four-bit bit position field
// - write-back: w13 or [w13] post-increment two
// - integer ops update c, dc, n, ov, z
// - dsp ops update per-accumulator overflow, saturate
// - size suffix byte, word, double; shadow select
// - mac names accumulator, operands, prefetch, write-back
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module dcid_decoder #(
	parameter int ADDR_W  = 8,
	parameter int COUNT_W = 16
) (
	input  wire logic                clock,
	input  wire logic                rst_n,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// fetch path from program memory
	input  wire logic [23:0]         fetchWord,
	input  wire logic                fetchValid,
	input  wire logic                condTrue,
	// decoded instruction
	output logic                     decValid,
	output logic      [7:0]          decOpcode,
	output logic      [3:0]          decClass,
	output logic      [1:0]          decCycles,
	output logic      [1:0]          sizeSel,
	output logic                     shadowSel,
	output logic      [3:0]          baseSourceRegister,
	output logic      [3:0]          secondSourceRegister,
	output logic      [1:0]          secondSourceMode,
	output logic      [3:0]          resultRegister,
	output logic      [1:0]          resultMode,
	output logic      [12:0]         fileAddress,
	output logic                     fileOpDefaultWorkingReg,
	output logic      [9:0]          tenBitUnsignedLiteral,
	output logic      [15:0]         signedLiteral,
	output logic      [22:0]         programAddressLiteral,
	output logic      [3:0]          bitPositionField,
	output logic                     accSelB,
	output logic      [3:0]          xPrefetch,
	output logic      [3:0]          yPrefetch,
	output logic      [1:0]          accWritebackTarget,
	output logic      [2:0]          mulPair,
	output logic      [4:0]          intFlagMask,
	output logic      [3:0]          dspFlagMask
);

	// sequencer: decode, second word, skip
	typedef enum logic [1:0] {
		DCID_IDLE    = 2'h0,
		DCID_SECOND  = 2'h1,
		DCID_SKIP    = 2'h3,
		DCID_SKIP2   = 2'h2
	} dcid_fsm_e;

	// bus, status and last decode in one record
	typedef struct packed {
		dcid_fsm_e          fsm;
		logic               enable;
		logic [3:0]         err;
		logic [COUNT_W-1:0] count;
		logic               pready;
		logic [31:0]        prdata;
		logic               pslverr;
		logic               valid;
		logic [7:0]         opcode;
		logic [3:0]         iclass;
		logic [1:0]         cycles;
		logic [1:0]         size;
		logic               shadow;
		logic [3:0]         base;
		logic [3:0]         src;
		logic [1:0]         srcMode;
		logic [3:0]         dst;
		logic [1:0]         dstMode;
		logic [12:0]        file;
		logic               fileToW0;
		logic [9:0]         litU;
		logic [15:0]        litS;
		logic [22:0]        progAddr;
		logic [3:0]         bitPos;
		logic               accB;
		logic [3:0]         xpf;
		logic [3:0]         ypf;
		logic [1:0]         acc_writeback_target;
		logic [2:0]         pair;
		logic [4:0]         intMask;
		logic [3:0]         dspMask;
	} dcid_state_s;

	dcid_state_s r;
	dcid_state_s next_r;

	// parameters the register map and counters cannot serve
	if (ADDR_W < 5 || ADDR_W > 8 || COUNT_W < 1 || COUNT_W > 32) begin : gBadParam
		$error("dcid_decoder: ADDR_W must be 5..8 and COUNT_W 1..32");
	end

	logic [7:0]  regAddr;
	logic [7:0]  op;
	logic [3:0]  cls;
	logic        take;
	logic        hit;
	logic [31:0] readData;
	logic [3:0]  errSet;
	logic [3:0]  errClr;
	logic        twoWordOp;

	assign regAddr = 8'(paddr);
	assign op      = fetchWord[dcid_pkg::OPC_LSB +: dcid_pkg::OPC_W];
	assign cls     = op[7:4];
	// disabled: fields and sequencer untouched
	assign take    = fetchValid & r.enable;
	// only the first three codes of the two-word class are real
	// the rest fall to the illegal branch
	assign twoWordOp = (cls == dcid_pkg::CLS_TWOW) && (op[3:0] < dcid_pkg::TWOW_COUNT);

	// register read mux; unmapped addresses read zero with an error
	always_comb begin
		hit      = 1'b1;
		readData = 32'h0;
		unique case (regAddr)
			dcid_pkg::OFF_CTRL:   readData = {31'h0, r.enable};
			dcid_pkg::OFF_STATUS: readData = {28'h0, r.err};
			dcid_pkg::OFF_LAST:   readData = {18'h0, r.cycles, r.iclass, r.opcode};
			dcid_pkg::OFF_COUNT:  readData = 32'(r.count);
			dcid_pkg::OFF_TARGET: readData = {9'h0, r.progAddr};
			default:              hit = 1'b0;
		endcase
	end

	// next state: bus slave, sticky errors and the decode sequencer
	always_comb begin
		next_r       = r;
		next_r.valid = 1'b0;
		next_r.pready  = 1'b0;
		next_r.pslverr = 1'b0;
		errSet = 4'h0;
		errClr = 4'h0;

		// one wait state keeps prdata a registered output
		if (psel && penable && !r.pready) begin
			next_r.pready  = 1'b1;
			next_r.prdata  = readData;
			next_r.pslverr = ~hit;
		end
		// writes land only at the completing edge
		if (psel && penable && r.pready && pwrite && hit) begin
			if (regAddr == dcid_pkg::OFF_CTRL) begin
				next_r.enable = pwdata[0];
			end
			if (regAddr == dcid_pkg::OFF_STATUS) begin
				errClr = pwdata[3:0];
			end
		end

		unique case (r.fsm)
			DCID_IDLE: begin
				if (take) begin
					// fields latched raw for every class
					next_r.opcode   = op;
					next_r.iclass   = cls;
					// operand fields, meaning depends on class
					next_r.base     = fetchWord[dcid_pkg::BASE_LSB +: 4];
					next_r.src      = fetchWord[dcid_pkg::SRC_LSB +: 4];
					next_r.srcMode  = fetchWord[dcid_pkg::SRC_MODE_LSB +: 2];
					next_r.dst      = fetchWord[dcid_pkg::DST_LSB +: 4];
					next_r.dstMode  = fetchWord[dcid_pkg::DST_MODE_LSB +: 2];
					next_r.file     = fetchWord[dcid_pkg::FILE_LSB +: 13];
					next_r.fileToW0 = fetchWord[dcid_pkg::FILE_DST_BIT];
					next_r.litU     = fetchWord[dcid_pkg::LITU_LSB +: 10];
					next_r.bitPos   = fetchWord[dcid_pkg::BITPOS_LSB +: 4];
					next_r.accB     = fetchWord[dcid_pkg::ACC_BIT];
					next_r.xpf      = fetchWord[dcid_pkg::XPF_LSB +: 4];
					next_r.ypf      = fetchWord[dcid_pkg::YPF_LSB +: 4];
					next_r.acc_writeback_target      = fetchWord[dcid_pkg::AWB_LSB +: 2];
					next_r.pair     = fetchWord[dcid_pkg::WPAIR_LSB +: 3];
					// sign extension of the two signed literal forms
					if (cls == dcid_pkg::CLS_LITS10) begin
						next_r.litS = {{6{fetchWord[dcid_pkg::LITS10_LSB + 9]}},
							fetchWord[dcid_pkg::LITS10_LSB +: 10]};
					end else begin
						next_r.litS = fetchWord[15:0];
					end
					// size suffix: word unless byte bit or double move
					if (cls == dcid_pkg::CLS_DWMOVE) begin
						next_r.size = dcid_pkg::SIZE_DOUBLE;
					end else if (op[dcid_pkg::BYTE_BIT]) begin
						next_r.size = dcid_pkg::SIZE_BYTE;
					end else begin
						next_r.size = dcid_pkg::SIZE_WORD;
					end
					next_r.shadow = (cls == dcid_pkg::CLS_RETURN) && op[dcid_pkg::SHADOW_BIT];
					// integer flags: logic ops touch only n and z
					next_r.intMask = 5'h00;
					if (cls == dcid_pkg::CLS_FILE_OP_DEFAULT_WORKING_REG || cls == dcid_pkg::CLS_FILE ||
						cls == dcid_pkg::CLS_LITU || cls == dcid_pkg::CLS_LITS10) begin
						next_r.intMask[dcid_pkg::FL_N] = 1'b1;
						next_r.intMask[dcid_pkg::FL_Z] = 1'b1;
						if (!op[dcid_pkg::LOGIC_BIT]) begin
							next_r.intMask[dcid_pkg::FL_C]  = 1'b1;
							next_r.intMask[dcid_pkg::FL_DC] = 1'b1;
							next_r.intMask[dcid_pkg::FL_OV] = 1'b1;
						end
					end
					// accumulator flags belong to the selected accumulator only
					next_r.dspMask = 4'h0;
					if (cls == dcid_pkg::CLS_MAC) begin
						if (fetchWord[dcid_pkg::ACC_BIT]) begin
							next_r.dspMask[dcid_pkg::FL_OB] = 1'b1;
							next_r.dspMask[dcid_pkg::FL_SB] = 1'b1;
						end else begin
							next_r.dspMask[dcid_pkg::FL_OA] = 1'b1;
							next_r.dspMask[dcid_pkg::FL_SA] = 1'b1;
						end
					end
					if (cls == dcid_pkg::CLS_LITU && op[dcid_pkg::BYTE_BIT] &&
						fetchWord[dcid_pkg::LITU_LSB +: 10] > dcid_pkg::BYTE_LIT_MAX) begin
						errSet[dcid_pkg::ERR_LITRNG] = 1'b1;
					end
					// cycle count and sequencing per class
					next_r.valid  = 1'b1;
					next_r.cycles = dcid_pkg::CYC_1;
					unique case (cls)
						dcid_pkg::CLS_CONDBR: begin
							next_r.cycles = condTrue ? dcid_pkg::CYC_2 : dcid_pkg::CYC_1;
						end
						dcid_pkg::CLS_BRANCH, dcid_pkg::CLS_TABLE, dcid_pkg::CLS_RETURN: begin
							next_r.cycles = op[dcid_pkg::LONG_BIT] ? dcid_pkg::CYC_3 : dcid_pkg::CYC_2;
						end
						dcid_pkg::CLS_DWMOVE: begin
							next_r.cycles = dcid_pkg::CYC_2;
						end
						dcid_pkg::CLS_SKIP: begin
							// cost of a taken skip depends on the next word
							if (condTrue) begin
								next_r.valid = 1'b0;
								next_r.fsm   = DCID_SKIP;
							end
						end
						dcid_pkg::CLS_TWOW: begin
							if (twoWordOp) begin
								next_r.valid    = 1'b0;
								next_r.progAddr = {7'h00, fetchWord[15:0]};
								next_r.fsm      = DCID_SECOND;
							end else begin
								errSet[dcid_pkg::ERR_ILLEGAL] = 1'b1;
							end
						end
						dcid_pkg::CLS_NOP: begin
							// a lone second word lands here: no effect at all
							next_r.intMask = 5'h00;
						end
						dcid_pkg::CLS_FILE_OP_DEFAULT_WORKING_REG, dcid_pkg::CLS_FILE, dcid_pkg::CLS_LITU,
						dcid_pkg::CLS_LITS16, dcid_pkg::CLS_LITS10, dcid_pkg::CLS_BIT,
						dcid_pkg::CLS_MAC: begin
							next_r.cycles = dcid_pkg::CYC_1;
						end
						default: begin
							errSet[dcid_pkg::ERR_ILLEGAL] = 1'b1;
						end
					endcase
				end
			end
			DCID_SECOND: begin
				if (take) begin
					// second word must have a zero opcode byte
					if (op != dcid_pkg::SECOND_TOP) begin
						errSet[dcid_pkg::ERR_SECOND] = 1'b1;
					end
					// odd check sees the first word itself
					if (r.progAddr[0]) begin
						errSet[dcid_pkg::ERR_ODDADDR] = 1'b1;
					end
					// 23-bit target from both words, forced even
					next_r.progAddr = {fetchWord[dcid_pkg::ADDR_HI_W-1:0], r.progAddr[15:1], 1'b0};
					next_r.cycles   = dcid_pkg::CYC_2;
					next_r.valid    = 1'b1;
					next_r.fsm      = DCID_IDLE;
				end
			end
			DCID_SKIP: begin
				if (take) begin
					// the skipped word is consumed, not decoded
					// a two-word victim costs a third cycle
					if (twoWordOp) begin
						next_r.cycles = dcid_pkg::CYC_3;
						next_r.fsm    = DCID_SKIP2;
					end else begin
						next_r.cycles = dcid_pkg::CYC_2;
						next_r.fsm    = DCID_IDLE;
					end
					next_r.valid = 1'b1;
				end
			end
			DCID_SKIP2: begin
				// swallow the second word of the skipped instruction
				if (take) begin
					next_r.fsm = DCID_IDLE;
				end
			end
		endcase

		// sticky errors: a set in the clearing cycle wins
		next_r.err = (r.err & ~errClr) | errSet;
		// count wraps; software reads differences
		if (next_r.valid) begin
			next_r.count = r.count + COUNT_W'(1);
		end
	end

	// state register
	// enable comes up set: no setup write needed
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r        <= '0;
			r.fsm    <= DCID_IDLE;
			r.enable <= dcid_pkg::RST_ENABLE;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the state register
	assign prdata                  = r.prdata;
	assign pready                  = r.pready;
	assign pslverr                 = r.pslverr;
	assign decValid                = r.valid;
	assign decOpcode               = r.opcode;
	assign decClass                = r.iclass;
	assign decCycles               = r.cycles;
	assign sizeSel                 = r.size;
	assign shadowSel               = r.shadow;
	assign baseSourceRegister      = r.base;
	assign secondSourceRegister    = r.src;
	assign secondSourceMode        = r.srcMode;
	assign resultRegister          = r.dst;
	assign resultMode              = r.dstMode;
	assign fileAddress             = r.file;
	assign fileOpDefaultWorkingReg = r.fileToW0;
	assign tenBitUnsignedLiteral   = r.litU;
	assign signedLiteral           = r.litS;
	assign programAddressLiteral   = r.progAddr;
	assign bitPositionField        = r.bitPos;
	assign accSelB                 = r.accB;
	assign xPrefetch               = r.xpf;
	assign yPrefetch               = r.ypf;
	assign accWritebackTarget      = r.acc_writeback_target;
	assign mulPair                 = r.pair;
	assign intFlagMask             = r.intMask;
	assign dspFlagMask             = r.dspMask;

endmodule : dcid_decoder

// file: dcid_decoder_sva.sv
// concurrent checks on the decoder fetch and decode ports
`timescale 1ns/100ps
module dcid_decoder_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [23:0] fetchWord,
	input wire logic        fetchValid,
	input wire logic        condTrue,
	input wire logic        decValid,
	input wire logic [7:0]  decOpcode,
	input wire logic [3:0]  decClass,
	input wire logic [1:0]  decCycles,
	input wire logic [1:0]  sizeSel,
	input wire logic [3:0]  baseSourceRegister,
	input wire logic [3:0]  secondSourceRegister,
	input wire logic [3:0]  resultRegister,
	input wire logic [12:0] fileAddress,
	input wire logic        fileOpDefaultWorkingReg,
	input wire logic [15:0] signedLiteral,
	input wire logic [22:0] programAddressLiteral,
	input wire logic [4:0]  intFlagMask,
	input wire logic [3:0]  dspFlagMask
);
	logic [23:0] pw;
	logic        pc;
	logic        pv;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// previous word and condition, the source of a one-word decode
	always_ff @(posedge clock) begin
		pw <= fetchWord;
		pc <= condTrue;
		pv <= fetchValid;
	end
	sequence sWordDec;
		decValid && decClass == dcid_pkg::CLS_FILE_OP_DEFAULT_WORKING_REG;
	endsequence
	sequence sFirstOfTwo;
		// a word eaten by a taken skip just before it raises the skip's decode pulse at once
		fetchValid && fetchWord[23:20] == dcid_pkg::CLS_TWOW && fetchWord[19:16] < 4'h3
			&& !(pv && pw[23:20] == dcid_pkg::CLS_SKIP && pc);
	endsequence
	AST_CLASS_OF_OPCODE: assert property (decValid |-> decClass == decOpcode[7:4])
		else $error("class does not follow opcode");
	AST_NO_EARLY_DEC: assert property (sFirstOfTwo |=> !decValid)
		else $error("decode on first word of two");
	AST_FILE_OP_DEFAULT_WORKING_REG_FIELDS: assert property (sWordDec |-> baseSourceRegister == pw[15:12]
		&& secondSourceRegister == pw[11:8] && resultRegister == pw[5:2]) else $error("register fields wrong");
	AST_SIZE_SEL: assert property (sWordDec |-> sizeSel == (pw[16] ? dcid_pkg::SIZE_BYTE : dcid_pkg::SIZE_WORD))
		else $error("size select wrong");
	AST_FILE_FIELDS: assert property (decValid && decClass == dcid_pkg::CLS_FILE |->
		fileAddress == pw[12:0] && fileOpDefaultWorkingReg == pw[13]) else $error("file fields wrong");
	AST_SIGNED_TEN: assert property (decValid && decClass == dcid_pkg::CLS_LITS10 |->
		signedLiteral == {{6{pw[13]}}, pw[13:4]}) else $error("signed literal not extended");
	AST_COND_CYCLES: assert property (decValid && decClass == dcid_pkg::CLS_CONDBR |->
		decCycles == (pc ? dcid_pkg::CYC_2 : dcid_pkg::CYC_1)) else $error("conditional cycles wrong");
	AST_LONG_CYCLES: assert property (decValid && decClass inside {4'h8, 4'hb, 4'hc} |->
		decCycles == (decOpcode[0] ? dcid_pkg::CYC_3 : dcid_pkg::CYC_2)) else $error("control cycles wrong");
	AST_TWO_WORD: assert property (decValid && decClass == dcid_pkg::CLS_TWOW && decOpcode[3:0] < 4'h3 |->
		decCycles == dcid_pkg::CYC_2 && !programAddressLiteral[0]) else $error("two-word decode wrong");
	AST_NOP_DEC: assert property (decValid && decClass == dcid_pkg::CLS_NOP |->
		decCycles == dcid_pkg::CYC_1 && intFlagMask == 5'h00 && dspFlagMask == 4'h0) else $error("nop not inert");
endmodule : dcid_decoder_chk
bind dcid_decoder dcid_decoder_chk chk_u (.clock(clock), .rst_n(rst_n), .fetchWord(fetchWord),
	.fetchValid(fetchValid), .condTrue(condTrue), .decValid(decValid), .decOpcode(decOpcode),
	.decClass(decClass), .decCycles(decCycles), .sizeSel(sizeSel), .baseSourceRegister(baseSourceRegister),
	.secondSourceRegister(secondSourceRegister), .resultRegister(resultRegister), .fileAddress(fileAddress),
	.fileOpDefaultWorkingReg(fileOpDefaultWorkingReg), .signedLiteral(signedLiteral),
	.programAddressLiteral(programAddressLiteral), .intFlagMask(intFlagMask), .dspFlagMask(dspFlagMask));

// file: dcid_fetch_model.sv
// program memory fetch path: hands one instruction word per request
`timescale 1ns/100ps
module dcid_fetch_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        reqStrobe,
	input  wire logic [23:0] reqWord,
	input  wire logic        reqCond,
	output logic      [23:0] fetchWord,
	output logic             fetchValid,
	output logic             condTrue
);
	// idle bus inverts its word every cycle so stale data never passes for valid
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetchWord  <= 24'h000000;
			fetchValid <= 1'b0;
			condTrue   <= 1'b0;
		end else if (reqStrobe) begin
			fetchWord  <= reqWord;
			fetchValid <= 1'b1;
			condTrue   <= reqCond;
		end else begin
			fetchWord  <= ~fetchWord;
			fetchValid <= 1'b0;
			condTrue   <= ~condTrue;
		end
	end
endmodule : dcid_fetch_model

// file: dcid_pkg.sv
// constants shared by the instruction decoder: layout, classes, register map
package dcid_pkg;
	// instruction word geometry
	localparam int WORD_W        = 24;
	localparam int OPC_LSB       = 16;
	localparam int OPC_W         = 8;
	// operand field positions inside the low 16 bits
	localparam int BASE_LSB      = 12;
	localparam int SRC_LSB       = 8;
	localparam int SRC_MODE_LSB  = 6;
	localparam int DST_LSB       = 2;
	localparam int DST_MODE_LSB  = 0;
	localparam int FILE_LSB      = 0;
	localparam int FILE_DST_BIT  = 13;
	localparam int LITU_LSB      = 4;
	localparam int LITS10_LSB    = 4;
	localparam int BITPOS_LSB    = 12;
	localparam int ACC_BIT       = 15;
	localparam int XPF_LSB       = 11;
	localparam int YPF_LSB       = 7;
	localparam int AWB_LSB       = 5;
	localparam int WPAIR_LSB     = 2;
	localparam int ADDR_HI_W     = 7;
	// opcode bit that selects byte mode, three cycles, the shadow set or a logic op
	localparam int BYTE_BIT      = 0;
	localparam int LONG_BIT      = 0;
	localparam int SHADOW_BIT    = 1;
	localparam int LOGIC_BIT     = 3;
	// instruction classes, taken from the upper opcode nibble
	localparam logic [3:0] CLS_NOP    = 4'h0;
	localparam logic [3:0] CLS_FILE_OP_DEFAULT_WORKING_REG   = 4'h1;
	localparam logic [3:0] CLS_FILE   = 4'h2;
	localparam logic [3:0] CLS_LITU   = 4'h3;
	localparam logic [3:0] CLS_LITS16 = 4'h4;
	localparam logic [3:0] CLS_LITS10 = 4'h5;
	localparam logic [3:0] CLS_BIT    = 4'h6;
	localparam logic [3:0] CLS_MAC    = 4'h7;
	localparam logic [3:0] CLS_BRANCH = 4'h8;
	localparam logic [3:0] CLS_CONDBR = 4'h9;
	localparam logic [3:0] CLS_SKIP   = 4'ha;
	localparam logic [3:0] CLS_TABLE  = 4'hb;
	localparam logic [3:0] CLS_RETURN = 4'hc;
	localparam logic [3:0] CLS_DWMOVE = 4'hd;
	localparam logic [3:0] CLS_TWOW   = 4'he;
	// number of distinct two-word instructions in the two-word class
	localparam logic [3:0] TWOW_COUNT = 4'h3;
	localparam logic [7:0] SECOND_TOP = 8'h00;
	localparam logic [9:0] BYTE_LIT_MAX = 10'h0ff;
	// cycle counts
	localparam logic [1:0] CYC_1 = 2'h1;
	localparam logic [1:0] CYC_2 = 2'h2;
	localparam logic [1:0] CYC_3 = 2'h3;
	// operand size codes
	localparam logic [1:0] SIZE_WORD   = 2'h0;
	localparam logic [1:0] SIZE_BYTE   = 2'h1;
	localparam logic [1:0] SIZE_DOUBLE = 2'h2;
	// integer flag mask bit positions
	localparam int FL_C  = 4;
	localparam int FL_DC = 3;
	localparam int FL_N  = 2;
	localparam int FL_OV = 1;
	localparam int FL_Z  = 0;
	// accumulator flag mask bit positions
	localparam int FL_OA = 3;
	localparam int FL_OB = 2;
	localparam int FL_SA = 1;
	localparam int FL_SB = 0;
	// sticky error bit positions
	localparam int ERR_SECOND  = 0;
	localparam int ERR_LITRNG  = 1;
	localparam int ERR_ODDADDR = 2;
	localparam int ERR_ILLEGAL = 3;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_LAST   = 8'h08;
	localparam logic [7:0] OFF_COUNT  = 8'h0c;
	localparam logic [7:0] OFF_TARGET = 8'h10;
	// values after reset
	localparam logic       RST_ENABLE = 1'b1;
endpackage : dcid_pkg

// file: tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
module tb;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, reqStrobe, reqCond, fetchValid, condTrue;
	logic [7:0] paddr, decOpcode;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] reqWord, fetchWord;
	logic decValid, shadowSel, fileOpDefaultWorkingReg, accSelB, err;
	logic [3:0] decClass, baseSourceRegister, secondSourceRegister, resultRegister, bitPositionField;
	logic [3:0] xPrefetch, yPrefetch, dspFlagMask;
	logic [1:0] decCycles, sizeSel, secondSourceMode, resultMode, accWritebackTarget;
	logic [12:0] fileAddress;
	logic [9:0] tenBitUnsignedLiteral;
	logic [15:0] signedLiteral;
	logic [22:0] programAddressLiteral;
	logic [2:0] mulPair;
	logic [4:0] intFlagMask;
	int nMismatch = 0, comparisons = 0, nDec = 0, cycles = 0, d0;
	dcid_decoder dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fetchWord(fetchWord), .fetchValid(fetchValid), .condTrue(condTrue), .decValid(decValid),
		.decOpcode(decOpcode), .decClass(decClass), .decCycles(decCycles), .sizeSel(sizeSel),
		.shadowSel(shadowSel), .baseSourceRegister(baseSourceRegister), .secondSourceRegister(secondSourceRegister),
		.secondSourceMode(secondSourceMode), .resultRegister(resultRegister), .resultMode(resultMode),
		.fileAddress(fileAddress), .fileOpDefaultWorkingReg(fileOpDefaultWorkingReg),
		.tenBitUnsignedLiteral(tenBitUnsignedLiteral), .signedLiteral(signedLiteral),
		.programAddressLiteral(programAddressLiteral), .bitPositionField(bitPositionField), .accSelB(accSelB),
		.xPrefetch(xPrefetch), .yPrefetch(yPrefetch), .accWritebackTarget(accWritebackTarget),
		.mulPair(mulPair), .intFlagMask(intFlagMask), .dspFlagMask(dspFlagMask));
	dcid_fetch_model mem_u (.clock(clock), .rst_n(rst_n), .reqStrobe(reqStrobe), .reqWord(reqWord),
		.reqCond(reqCond), .fetchWord(fetchWord), .fetchValid(fetchValid), .condTrue(condTrue));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// decode pulses and the hang guard, sized well above the whole sequence
	always @(posedge clock) begin
		cycles++;
		if (decValid === 1'b1) nDec++;
		if (cycles == 20000) begin
			nMismatch++;
			conclude();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one apb transfer; a clock edge passes before the next setup may start
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	// words go out back to back, then wait for the decode pulse
	task automatic send(input logic [23:0] w[$], input logic c);
		d0 = nDec;
		reqStrobe <= 1'b1;
		reqCond <= c;
		foreach (w[i]) begin
			reqWord <= w[i];
			@(posedge clock);
		end
		reqStrobe <= 1'b0;
		for (int k = 0; k < 8 && decValid !== 1'b1; k++) @(negedge clock);
		@(posedge clock);
		repeat (2) @(posedge clock);
	endtask : send
	task automatic tRegs;
		apb(1'b0, dcid_pkg::OFF_CTRL, 32'h0);
		check("ctrl", rd, 32'h1);
		apb(1'b0, dcid_pkg::OFF_STATUS, 32'h0);
		check("status", rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		$display("test regs done");
	endtask : tRegs
	task automatic tOperands;
		send('{24'h11a5c7}, 1'b0);
		check("one decode", nDec - d0, 1);
		check("class", decClass, 4'h1);
		check("fields", {baseSourceRegister, secondSourceRegister, secondSourceMode, resultRegister, resultMode},
			{4'ha, 4'h5, 2'h3, 4'h1, 2'h3});
		check("size", sizeSel, dcid_pkg::SIZE_BYTE);
		check("int mask", intFlagMask, 5'h1f);
		apb(1'b0, dcid_pkg::OFF_LAST, 32'h0);
		check("last", rd, 32'h00001111);
		send('{24'h180000}, 1'b0);
		check("logic mask", intFlagMask, 5'h05);
		send('{24'h203fff}, 1'b0);
		check("file", {fileOpDefaultWorkingReg, fileAddress}, {1'b1, 13'h1fff});
		send('{24'h502000}, 1'b0);
		check("ten_bit_signed_literal", signedLiteral, 16'hfe00);
		send('{24'h60f000}, 1'b0);
		check("bit pos", bitPositionField, 4'hf);
		send('{24'h708a65}, 1'b0);
		check("mac", {accSelB, xPrefetch, yPrefetch, accWritebackTarget, mulPair},
			{1'b1, 4'h1, 4'h4, 2'h3, 3'h1});
		check("dsp mask", dspFlagMask, 4'h5);
		send('{24'h408000}, 1'b0);
		check("sixteen_bit_signed_literal", signedLiteral, 16'h8000);
		send('{24'h311000}, 1'b0);
		check("ten_bit_unsigned_literal", tenBitUnsignedLiteral, 10'h100);
		apb(1'b0, dcid_pkg::OFF_STATUS, 32'h0);
		check("byte lit flag", rd, 32'h2);
		apb(1'b1, dcid_pkg::OFF_STATUS, 32'hf);
		$display("test operands done");
	endtask : tOperands
	task automatic tCycles;
		// opcode, condition, cycles
		logic [10:0] tbl[9] = '{{8'h80, 1'b0, 2'h2}, {8'h81, 1'b0, 2'h3}, {8'hb1, 1'b0, 2'h3},
			{8'hc2, 1'b0, 2'h2}, {8'hd0, 1'b0, 2'h2}, {8'h90, 1'b0, 2'h1}, {8'h90, 1'b1, 2'h2},
			{8'h10, 1'b1, 2'h1}, {8'hc1, 1'b0, 2'h3}};
		foreach (tbl[i]) begin
			send('{{tbl[i][10:3], 16'h0000}}, tbl[i][2]);
			check("cycles", decCycles, tbl[i][1:0]);
			check("shadow", shadowSel, tbl[i][10:3] == 8'hc2);
		end
		$display("test cycles done");
	endtask : tCycles
	task automatic tTwoWord;
		send('{24'he01234, 24'h000056}, 1'b0);
		check("two-word pulses", nDec - d0, 1);
		check("target", programAddressLiteral, {7'h56, 15'h091a, 1'b0});
		check("two-word cycles", decCycles, 2'h2);
		send('{24'he11235, 24'h120000}, 1'b0);
		apb(1'b0, dcid_pkg::OFF_STATUS, 32'h0);
		check("bad second", rd, 32'h5);
		check("forced even", programAddressLiteral[0], 1'b0);
		apb(1'b1, dcid_pkg::OFF_STATUS, 32'h5);
		send('{24'h000056}, 1'b0);
		check("lone second", {decClass, decCycles, intFlagMask, dspFlagMask}, {4'h0, 2'h1, 9'h000});
		send('{24'ha00000, 24'he00000, 24'h000000}, 1'b1);
		check("skip two-word pulses", nDec - d0, 1);
		check("skip two-word cycles", decCycles, 2'h3);
		send('{24'ha00000, 24'h110000}, 1'b1);
		check("skip one-word pulses", nDec - d0, 1);
		check("skip one-word cycles", decCycles, 2'h2);
		$display("test two-word done");
	endtask : tTwoWord
	task automatic tEnable;
		logic [31:0] c0;
		apb(1'b1, dcid_pkg::OFF_CTRL, 32'h0);
		apb(1'b0, dcid_pkg::OFF_COUNT, 32'h0);
		c0 = rd;
		send('{24'h110000}, 1'b0);
		check("disabled", nDec - d0, 0);
		apb(1'b1, dcid_pkg::OFF_CTRL, 32'h1);
		send('{24'hf00000}, 1'b0);
		apb(1'b0, dcid_pkg::OFF_COUNT, 32'h0);
		check("count", rd, c0 + 32'h1);
		send('{24'he30000}, 1'b0);
		check("reserved pulses", nDec - d0, 1);
		check("reserved cycles", decCycles, 2'h1);
		apb(1'b0, dcid_pkg::OFF_STATUS, 32'h0);
		check("illegal", rd, 32'h8);
		$display("test enable done");
	endtask : tEnable
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, nMismatch);
		if (nMismatch == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, reqStrobe, reqCond} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		reqWord = 24'h000000;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		tRegs();
		tOperands();
		tCycles();
		tTwoWord();
		tEnable();
		conclude();
	end
endmodule : tb
